// ### hdl/accum_shift_rotate_exec.sv
/*
  Phase-1 fetch and execute datapath for single-bit shifts and rotates of
  the A and B accumulators, with program counter step and next phase.
  Assumes an APB master on pclk; software loads the memory word to start
  one machine cycle of eight time periods.
*/
`timescale 1ns/100ps
`include "accum_shift_map.svh"

module accum_shift_rotate_exec
  import exec_pkg::*;
(
  input wire logic pclk, // 100 MHz clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped or busy write
  output uop_t uop, // Micro-operation strobes
  output tstate_t tstate, // Current time period
  output logic busy // Machine cycle in progress
);

  // ****************************************
  // Declarations
  // ****************************************
  logic busy_q;
  tstate_t t_q;
  logic [15:0] mem_word_q;
  logic [15:0] tr_q;
  logic [5:0] ir_q;
  logic [15:0] a_q;
  logic [15:0] b_q;
  logic [15:0] p_q;
  logic [15:0] m_q;
  logic carry_q;
  logic extend_q;
  logic loop_q;
  logic int_q;
  logic [2:0] phase_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic setup_rd;
  logic acc_en;
  logic mapped;
  logic grp_hit;
  logic b_sel;
  logic [3:0] sel;
  logic [15:0] acc;
  logic [15:0] rbus;
  logic [15:0] tbus;
  logic rbus_bit0;
  uop_t u;

  // ****************************************
  // APB slave
  // ****************************************
  assign acc_en = psel & penable;
  assign wr_en = acc_en & pwrite & ~busy_q;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      `OFS_A_ACCUM, `OFS_B_ACCUM, `OFS_P_REG, `OFS_M_REG,
      `OFS_MEM_WORD, `OFS_CTRL, `OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = acc_en & (~mapped | (pwrite & busy_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_q <= 32'h00000000;
      case (paddr)
        `OFS_A_ACCUM: prdata_q[15:0] <= a_q;
        `OFS_B_ACCUM: prdata_q[15:0] <= b_q;
        `OFS_P_REG: prdata_q[15:0] <= p_q;
        `OFS_M_REG: prdata_q[15:0] <= m_q;
        `OFS_MEM_WORD: prdata_q[15:0] <= mem_word_q;
        `OFS_CTRL: begin
          prdata_q[`CTRL_LOOP_BIT] <= loop_q;
          prdata_q[`CTRL_INT_BIT] <= int_q;
        end
        `OFS_STATUS: begin
          prdata_q[`ST_BUSY_BIT] <= busy_q;
          prdata_q[`ST_CARRY_BIT] <= carry_q;
          prdata_q[`ST_EXTEND_BIT] <= extend_q;
          prdata_q[`ST_PHASE_MSB:`ST_PHASE_LSB] <= phase_q;
          prdata_q[`ST_TSTATE_MSB:`ST_TSTATE_LSB] <= t_q;
        end
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_q <= 1'b0;
      int_q <= 1'b0;
    end else if (wr_en && paddr == `OFS_CTRL) begin
      loop_q <= pwdata[`CTRL_LOOP_BIT];
      int_q <= pwdata[`CTRL_INT_BIT];
    end
  end

  // ****************************************
  // Timing generator
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      t_q <= T0;
    end else if (!busy_q) begin
      if (wr_en && paddr == `OFS_MEM_WORD) begin
        busy_q <= 1'b1;
        t_q <= T0;
      end
    end else begin
      case (t_q)
        T0: t_q <= T1;
        T1: t_q <= T2;
        T2: t_q <= T3;
        T3: t_q <= T4;
        T4: t_q <= T5;
        T5: t_q <= T6;
        T6: t_q <= T7;
        T7: begin
          t_q <= T0;
          busy_q <= 1'b0;
        end
        default: t_q <= T0;
      endcase
    end
  end

  assign tstate = t_q;
  assign busy = busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_word_q <= `WORD_RST;
    end else if (wr_en && paddr == `OFS_MEM_WORD) begin
      mem_word_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // Fetch: memory data holding and instruction latch
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_q <= `WORD_RST;
    end else if (busy_q && t_q == T0) begin
      tr_q <= `WORD_RST;
    end else if (busy_q && t_q == T1) begin
      tr_q <= mem_word_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_q <= `IR_RST;
    end else if (busy_q && t_q == T1) begin
      ir_q <= `IR_RST;
    end else if (busy_q && t_q == T2) begin
      ir_q <= tr_q[`IR_HI:`IR_LO];
    end
  end

  // ****************************************
  // Decode and micro-operations
  // ****************************************
  assign grp_hit = busy_q && (ir_q[`GRP_HI:`GRP_LO] == `GRP_ZERO || ir_q[`GRP_HI:`GRP_LO] == `GRP_TWO);
  assign b_sel = ir_q[`IR_BSEL_BIT];
  assign sel = tr_q[`TR_SEL_HI:`TR_SEL_LO];
  assign acc = b_sel ? b_q : a_q;

  always_comb begin
    u = '0;
    rbus = `WORD_RST;
    case (t_q)
      T3, T5: begin
        if (grp_hit) begin
          u.shift_group_active = 1'b1;
          u.opgroup_zero_decode = 1'b1;
          u.a_accum_onto_rbus = ~b_sel;
          u.b_accum_onto_rbus = b_sel;
          u.write_a_accum = ~b_sel;
          u.write_b_accum = b_sel;
          rbus = acc;
          if (t_q == T3) begin
            case (sel)
              `SEL_ARS: begin
                u.shift_right_one = 1'b1;
              end
              `SEL_RAL: begin
                u.shift_left_one = 1'b1;
                u.rotate_left_wrap = 1'b1;
                u.left_wrap_bit_path = 1'b1;
              end
              `SEL_RAR: begin
                u.shift_right_one = 1'b1;
                u.rotate_right_wrap = 1'b1;
              end
              default: begin
                u.shift_right_one = 1'b0;
              end
            endcase
          end
        end
      end
      T4: begin
        if (grp_hit && tr_q[`TR_SKIP_BIT]) begin
          u.shift_group_active = 1'b1;
          u.a_accum_onto_rbus = ~b_sel;
          u.b_accum_onto_rbus = b_sel;
          rbus = acc;
        end
      end
      T6, T7: begin
        if (busy_q) begin
          u.pc_onto_rbus = 1'b1;
          u.add_function_select = 1'b1;
          u.p_to_address_strobe = ~loop_q;
          u.p_load_strobe = ~loop_q;
          u.m_load_strobe = ~loop_q;
          rbus = p_q;
        end
      end
      default: begin
        rbus = `WORD_RST;
      end
    endcase
  end

  assign uop = u;
  assign rbus_bit0 = rbus[0];

  // ****************************************
  // Shifter and adder onto the T-bus
  // ****************************************
  always_comb begin
    tbus = rbus;
    if (u.add_function_select) begin
      tbus = rbus + `PC_STEP + {15'h0000, carry_q};
    end else if (u.shift_right_one) begin
      tbus = {u.rotate_right_wrap ? rbus[0] : rbus[15], rbus[15:1]};
    end else if (u.shift_left_one) begin
      tbus = {u.left_wrap_bit_path ? rbus[14] : rbus[15], rbus[13:0],
              u.rotate_left_wrap ? rbus[15] : 1'b0};
    end
  end

  // ****************************************
  // Accumulators
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= `WORD_RST;
    end else if (u.write_a_accum) begin
      a_q <= tbus;
    end else if (wr_en && paddr == `OFS_A_ACCUM) begin
      a_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_q <= `WORD_RST;
    end else if (u.write_b_accum) begin
      b_q <= tbus;
    end else if (wr_en && paddr == `OFS_B_ACCUM) begin
      b_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // Program counter and memory address
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_q <= `WORD_RST;
    end else if (u.p_load_strobe && t_q == T7) begin
      p_q <= tbus;
    end else if (wr_en && paddr == `OFS_P_REG) begin
      p_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_q <= `WORD_RST;
    end else if (u.m_load_strobe && t_q == T7) begin
      m_q <= tbus;
    end else if (wr_en && paddr == `OFS_P_REG) begin
      m_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // Carry, extend and next phase
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
    end else if (busy_q && t_q == T0) begin
      carry_q <= 1'b0;
    end else if (t_q == T4 && u.shift_group_active && !rbus_bit0) begin
      carry_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extend_q <= 1'b0;
    end else if (wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_SET_EXT_BIT]) begin
      extend_q <= 1'b1;
    end else if (grp_hit && t_q == T4 && tr_q[`TR_CLE_BIT]) begin
      extend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= `PHASE_FETCH;
    end else if (busy_q && t_q == T7) begin
      phase_q <= int_q ? `PHASE_INT : `PHASE_FETCH;
    end
  end

endmodule

// ### hdl/accum_shift_map.svh
/*
  Register offsets, field positions, decode values and reset values of the
  accumulator shift and rotate datapath.
  Assumes inclusion by bare name, once per compilation unit.
*/
`ifndef ACCUM_SHIFT_MAP_SVH
`define ACCUM_SHIFT_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_A_ACCUM 8'h00
`define OFS_B_ACCUM 8'h04
`define OFS_P_REG 8'h08
`define OFS_M_REG 8'h0C
`define OFS_MEM_WORD 8'h10
`define OFS_CTRL 8'h14
`define OFS_STATUS 8'h18

// ****************************************
// Control and status fields
// ****************************************
`define CTRL_LOOP_BIT 0
`define CTRL_INT_BIT 1
`define CTRL_SET_EXT_BIT 2
`define ST_BUSY_BIT 0
`define ST_CARRY_BIT 1
`define ST_EXTEND_BIT 2
`define ST_PHASE_LSB 4
`define ST_PHASE_MSB 6
`define ST_TSTATE_LSB 8
`define ST_TSTATE_MSB 10

// ****************************************
// Instruction fields and decodes
// ****************************************
`define WORD_W 16
`define IR_HI 15
`define IR_LO 10
`define GRP_HI 5
`define GRP_LO 2
`define GRP_ZERO 4'h0
`define GRP_TWO 4'h2
`define IR_BSEL_BIT 1
`define TR_SEL_HI 9
`define TR_SEL_LO 6
`define SEL_ARS 4'h9
`define SEL_RAL 4'hA
`define SEL_RAR 4'hB
`define TR_CLE_BIT 5
`define TR_SKIP_BIT 3

// ****************************************
// Reset and phase values
// ****************************************
`define WORD_RST 16'h0000
`define IR_RST 6'h00
`define PHASE_FETCH 3'h1
`define PHASE_INT 3'h4
`define PC_STEP 16'h0001

`endif

// ### hdl/exec_pkg.sv
/*
  Types shared by the shift and rotate datapath: time periods and the
  micro-operation strobe bundle.
  Assumes no other package.
*/
package exec_pkg;

  // Time periods, Gray coded along T0..T7
  typedef enum logic [2:0] {
    T0 = 3'h0,
    T1 = 3'h1,
    T2 = 3'h3,
    T3 = 3'h2,
    T4 = 3'h6,
    T5 = 3'h7,
    T6 = 3'h5,
    T7 = 3'h4
  } tstate_t;

  typedef struct packed {
    logic shift_group_active;
    logic opgroup_zero_decode;
    logic a_accum_onto_rbus;
    logic b_accum_onto_rbus;
    logic write_a_accum;
    logic write_b_accum;
    logic shift_right_one;
    logic shift_left_one;
    logic rotate_left_wrap;
    logic left_wrap_bit_path;
    logic rotate_right_wrap;
    logic p_to_address_strobe;
    logic pc_onto_rbus;
    logic add_function_select;
    logic p_load_strobe;
    logic m_load_strobe;
  } uop_t;

endpackage

// ### verification/shift_exec_chk.sv
/*
  Port checker for the shift and rotate datapath.
  Assumes binding to accum_shift_rotate_exec and exec_pkg compiled first.
*/
`timescale 1ns/100ps
module shift_exec_chk
  import exec_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input uop_t uop, // Strobes
  input tstate_t tstate, // Time period
  input wire logic busy // Cycle running
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fetch;
    tstate == T0 ##1 tstate == T1 ##1 tstate == T2 ##1 tstate == T3;
  endsequence
  sequence s_exec;
    tstate == T4 ##1 tstate == T5 ##1 tstate == T6 ##1 tstate == T7;
  endsequence
  AST_CYCLE: assert property ($rose(busy) |-> s_fetch ##1 s_exec ##1 !busy)
    else $error("time periods out of order");
  AST_BUSY: assert property ($rose(busy) |-> busy [*8] ##1 !busy)
    else $error("busy length wrong");
  AST_SRM: assert property (uop.shift_right_one |-> tstate == T3 && uop.shift_group_active && uop.opgroup_zero_decode)
    else $error("right shift outside shift slot");
  AST_RLW: assert property (uop.rotate_left_wrap |-> uop.shift_left_one && uop.left_wrap_bit_path)
    else $error("rotate left strobes incomplete");
  AST_RRW: assert property (uop.rotate_right_wrap |-> uop.shift_right_one && !uop.shift_left_one)
    else $error("rotate right strobes wrong");
  AST_ONE_ACC: assert property (uop.write_a_accum |-> !uop.write_b_accum && uop.a_accum_onto_rbus)
    else $error("both accumulators selected");
  AST_WR_SLOT: assert property ((uop.write_a_accum || uop.write_b_accum) |-> tstate inside {T3, T5})
    else $error("accumulator store outside T3 or T5");
  AST_PC: assert property (busy && tstate == T6 |-> uop.pc_onto_rbus && uop.add_function_select ##1 uop.pc_onto_rbus)
    else $error("pc increment strobes missing");
  AST_LOAD: assert property (uop.p_load_strobe |-> uop.m_load_strobe && tstate inside {T6, T7})
    else $error("P load without M load");
  AST_BUSY_WR: assert property (psel && penable && pwrite && busy |-> pslverr)
    else $error("write while busy not refused");
  AST_SBO: assert property (uop.p_to_address_strobe |-> uop.pc_onto_rbus && uop.p_load_strobe)
    else $error("address strobe outside pc step");
endmodule

bind accum_shift_rotate_exec shift_exec_chk shift_exec_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .uop(uop), .tstate(tstate), .busy(busy));

// ### verification/apb_master_model.sv
/*
  APB master standing in for the processor side of the register bus.
  Assumes a slave that answers with pready; waits with no fixed count.
*/
`timescale 1ns/100ps
module apb_master_model (
  input wire logic pclk, // Clock
  output logic psel, // APB select
  output logic penable, // APB access
  output logic pwrite, // APB direction
  output logic [7:0] paddr, // APB address
  output logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  // ****************************************
  // Bus cycle
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### verification/tb.sv
/*
  Self-checking bench for the shift and rotate datapath over APB.
  Assumes the design package, register map and bus model compiled first.
*/
`timescale 1ns/100ps
`include "accum_shift_map.svh"
module tb
  import exec_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] p_exp;
  uop_t uop;
  tstate_t tstate;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] ops [3] = '{16'h0240, 16'h0280, 16'h02C0};
  logic [15:0] vals [3] = '{16'h5555, 16'h8000, 16'h0001};

  always #5 pclk = ~pclk;

  accum_shift_rotate_exec accum_shift_rotate_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uop(uop), .tstate(tstate), .busy(busy));
  apb_master_model apb_master_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ****************************************
  // Tasks
  // ****************************************
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    apb_master_model_inst.xfer(1'b1, a, {16'h0000, d}, q, e);
  endtask
  task rd(input logic [7:0] a);
    apb_master_model_inst.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  task wait_idle;
    int i;
    i = 0;
    do begin
      rd(`OFS_STATUS);
      i++;
    end while (q[`ST_BUSY_BIT] !== 1'b0 && i < 20);
    check("busy", 32'(q[`ST_BUSY_BIT]), 32'h0);
  endtask
  task run(input logic [15:0] w);
    wr(`OFS_MEM_WORD, w);
    wait_idle();
  endtask
  function automatic logic [15:0] shx(input logic [15:0] w, input logic [15:0] x);
    case (w[9:6])
      4'h9: return {x[15], x[15:1]};
      4'hA: return {x[14:0], x[15]};
      default: return {x[0], x[15:1]};
    endcase
  endfunction
  task finish_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      finish_test;
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_STATUS);
    check("phase_rst", 32'(q[6:4]), 32'(`PHASE_FETCH));
    wr(`OFS_P_REG, 16'h0200);
    p_exp = 16'h0200;
    for (int b = 0; b < 2; b++) begin
      for (int o = 0; o < 3; o++) begin
        for (int k = 0; k < 3; k++) begin
          wr(b ? `OFS_B_ACCUM : `OFS_A_ACCUM, vals[k]);
          wr(b ? `OFS_A_ACCUM : `OFS_B_ACCUM, 16'h1234);
          run(ops[o] | (b ? 16'h0800 : 16'h0000));
          rd(b ? `OFS_B_ACCUM : `OFS_A_ACCUM);
          check("acc", q, 32'(shx(ops[o], vals[k])));
          rd(b ? `OFS_A_ACCUM : `OFS_B_ACCUM);
          check("other_acc", q, 32'h00001234);
          p_exp = p_exp + 16'h0001;
          rd(`OFS_M_REG);
          check("m_step", q, 32'(p_exp));
        end
      end
    end
    $display("test shift_rotate done");
    wr(`OFS_A_ACCUM, 16'h0004);
    run(16'h0248);
    rd(`OFS_STATUS);
    check("carry", 32'(q[`ST_CARRY_BIT]), 32'h1);
    p_exp = p_exp + 16'h0002;
    rd(`OFS_P_REG);
    check("p_carry", q, 32'(p_exp));
    wr(`OFS_CTRL, 16'h0004);
    rd(`OFS_STATUS);
    check("ext_set", 32'(q[`ST_EXTEND_BIT]), 32'h1);
    run(16'h0260);
    rd(`OFS_STATUS);
    check("ext_clr", 32'(q[`ST_EXTEND_BIT]), 32'h0);
    $display("test carry_extend done");
    rd(8'h1C);
    check("unmapped_err", 32'(e), 32'h1);
    wr(`OFS_MEM_WORD, 16'h0280);
    wr(`OFS_A_ACCUM, 16'hFFFF);
    check("busy_wr_err", 32'(e), 32'h1);
    wait_idle();
    rd(`OFS_A_ACCUM);
    check("busy_wr_ign", q, 32'h00000002);
    p_exp = p_exp + 16'h0002;
    $display("test refusal done");
    wr(`OFS_CTRL, 16'h0003);
    run(16'h0280);
    rd(`OFS_P_REG);
    check("p_loop", q, 32'(p_exp));
    rd(`OFS_M_REG);
    check("m_loop", q, 32'(p_exp));
    rd(`OFS_STATUS);
    check("phase_int", 32'(q[6:4]), 32'(`PHASE_INT));
    wr(`OFS_CTRL, 16'h0000);
    run(16'h0280);
    rd(`OFS_STATUS);
    check("phase_one", 32'(q[6:4]), 32'(`PHASE_FETCH));
    $display("test loop_phase done");
    finish_test;
  end
endmodule
